// ---- rtl/scs_consts.svh ----
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH

// register addresses
`define SCS_ADDR_CONFIG 8'ha1
`define SCS_ADDR_DIVIDER 8'ha2
`define SCS_ADDR_DATA 8'ha3
`define SCS_ADDR_CONTROL 8'hf8

// control register fields
`define SCS_BIT_DONE 7
`define SCS_BIT_WRITE_COLLISION_FLAG 6
`define SCS_BIT_MODE_FAULT_FLAG 5
`define SCS_BIT_OVR 4
`define SCS_BIT_SEL_HI 3
`define SCS_BIT_SEL_LO 2
`define SCS_BIT_TX_BUFFER_EMPTY 1
`define SCS_BIT_EN 0

// configuration register fields
`define SCS_BIT_BUSY 7
`define SCS_BIT_MASTER_ENABLE 6
`define SCS_BIT_SELECTED 3
`define SCS_BIT_PIN 2
`define SCS_BIT_RXBMT 0

// reset values
`define SCS_RST_CONTROL 8'h06
`define SCS_RST_DIVIDER 8'h00
`define SCS_RST_MASTER_ENABLE 1'h0
`define SCS_RST_TXBUF 8'h00

// select pin modes
`define SCS_SEL_3WIRE 2'h0
`define SCS_SEL_INPUT 2'h1

`endif

// ---- rtl/scs_pkg.sv ----
`default_nettype none

package scs_pkg;

  typedef logic [7:0] reg_byte_t;
  typedef logic [1:0] select_mode_t;

endpackage

`default_nettype wire

// ---- rtl/spi_control_status_clock.sv ----
// Notes on behaviour
// - transfer done flag sets when a transfer ends, master or slave.
// - the four event flags stay set until software writes zero.
// - any set event flag with interrupt enabled raises the interrupt request.
// - data write while transmit buffer is full sets write collision flag.
// - a colliding data write is dropped; transmit buffer keeps its contents.
// - mode fault sets when master, select mode 01, select input low.
// - slave overrun sets when last bit arrives while receive data unread.
// - select mode 00 is three-wire; select pin not connected.
// - select mode 01, the reset default, makes the select pin an input.
// - select mode 1x drives the select pin with the mode low bit.
// - transmit buffer empty drops to 0 when the buffer is written.
// - transmit buffer empty rises when data moves to the shift register.
// - master serial clock is system clock over 2 times (divider plus one).
// - divider drives the serial clock only in master mode.
// - control register at 0xf8, with single-bit set and clear writes.
// - data write loads transmit buffer; data read returns receive buffer.
// - master enable 1 selects master, 0 slave; mode fault depends on it.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "scs_consts.svh"

module spi_control_status_clock
  import scs_pkg::*;
#(
  parameter int RX_WIDTH = 8,
  parameter int RX_DEPTH = 2
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic bit_wr_in,
  input wire logic [2:0] bit_idx_in,
  input wire logic bit_val_in,
  input wire logic irq_enable_in,
  output logic irq_out,
  input wire logic busy_in,
  input wire logic xfer_done_in,
  input wire logic last_bit_in,
  output logic [7:0] tx_data_out,
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  input wire logic [RX_WIDTH-1:0] rx_data_in,
  input wire logic rx_valid_in,
  output logic rx_ready_out,
  output logic master_enable_out,
  output logic port_enable_out,
  output logic slave_selected_out,
  output logic serial_clk_out,
  output logic serial_clk_edge_out,
  input wire logic select_pin_in,
  output logic select_pin_out,
  output logic select_pin_oe_n_out
);

  localparam int AW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;

  // refuse buffer shapes the pointer and read logic cannot serve
  if (RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0 || RX_WIDTH != 8) begin : g_bad_shape
    $error("receive buffer needs power-of-two depth of at least 2 and width 8");
  end

  // ----------------------------------------------------------------
  // registers and decode
  // ----------------------------------------------------------------
  reg_byte_t ctrl_q, ctrl_d;
  reg_byte_t div_q;
  reg_byte_t tx_buf_q;
  reg_byte_t rdata_q;
  logic master_enable_q;
  logic pin_meta_q, pin_sync_q;
  logic [7:0] cnt_q;
  logic sck_q, sck_edge_q;
  logic [RX_WIDTH-1:0] rx_mem_q [RX_DEPTH];
  logic [AW-1:0] rx_wp_q, rx_rp_q;
  logic [AW:0] rx_cnt_q;

  wire sel_ctrl = (addr_in == `SCS_ADDR_CONTROL);
  wire sel_div = (addr_in == `SCS_ADDR_DIVIDER);
  wire sel_data = (addr_in == `SCS_ADDR_DATA);
  wire sel_cfg = (addr_in == `SCS_ADDR_CONFIG);
  wire ctrl_wr = wr_in && sel_ctrl;
  wire data_wr = wr_in && sel_data;
  wire data_rd = rd_in && sel_data;
  wire ctrl_touch = ctrl_wr || bit_wr_in;

  wire enabled = ctrl_q[`SCS_BIT_EN];
  wire tx_buffer_empty = ctrl_q[`SCS_BIT_TX_BUFFER_EMPTY];
  wire select_mode_t sel_mode = ctrl_q[`SCS_BIT_SEL_HI:`SCS_BIT_SEL_LO];
  wire [3:0] ev_flags = ctrl_q[`SCS_BIT_DONE:`SCS_BIT_OVR];

  // ----------------------------------------------------------------
  // select pin
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      pin_meta_q <= 1'h1;
      pin_sync_q <= 1'h1;
    end else begin
      pin_meta_q <= select_pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  wire drive_pin = sel_mode[1];
  assign select_pin_oe_n_out = !drive_pin;
  assign select_pin_out = drive_pin && sel_mode[0];
  assign slave_selected_out = (sel_mode == `SCS_SEL_3WIRE) ? 1'h1 : !pin_sync_q;

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  wire rx_empty = (rx_cnt_q == '0);
  wire rx_full = (rx_cnt_q == (AW+1)'(RX_DEPTH));
  wire tx_take = tx_valid_out && tx_ready_in;
  wire set_done = enabled && xfer_done_in;
  wire set_write_collision_flag = data_wr && !tx_buffer_empty;
  wire set_mode_fault_flag = enabled && master_enable_q && (sel_mode == `SCS_SEL_INPUT) && !pin_sync_q;
  wire set_ovr = enabled && !master_enable_q && last_bit_in && !rx_empty;
  wire tx_load = data_wr && tx_buffer_empty;
  wire [3:0] ev_set = {set_done, set_write_collision_flag, set_mode_fault_flag, set_ovr};

  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrl_wr) begin
      ctrl_d = wdata_in;
    end else if (bit_wr_in) begin
      ctrl_d[bit_idx_in] = bit_val_in;
    end
    ctrl_d[`SCS_BIT_DONE:`SCS_BIT_OVR] = ctrl_d[`SCS_BIT_DONE:`SCS_BIT_OVR] | ev_set;
    if (tx_load) begin
      ctrl_d[`SCS_BIT_TX_BUFFER_EMPTY] = 1'h0;
    end else if (tx_take) begin
      ctrl_d[`SCS_BIT_TX_BUFFER_EMPTY] = 1'h1;
    end else begin
      ctrl_d[`SCS_BIT_TX_BUFFER_EMPTY] = tx_buffer_empty;
    end
  end

  assign irq_out = irq_enable_in && (|ev_flags);

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      ctrl_q <= `SCS_RST_CONTROL;
      div_q <= `SCS_RST_DIVIDER;
      master_enable_q <= `SCS_RST_MASTER_ENABLE;
      tx_buf_q <= `SCS_RST_TXBUF;
    end else begin
      ctrl_q <= ctrl_d;
      if (wr_in && sel_div) begin
        div_q <= wdata_in;
      end
      if (wr_in && sel_cfg) begin
        master_enable_q <= wdata_in[`SCS_BIT_MASTER_ENABLE];
      end
      if (tx_load) begin
        tx_buf_q <= wdata_in;
      end
    end
  end

  assign tx_data_out = tx_buf_q;
  assign tx_valid_out = enabled && !tx_buffer_empty;
  assign master_enable_out = master_enable_q;
  assign port_enable_out = enabled;

  // ----------------------------------------------------------------
  // receive buffer
  // ----------------------------------------------------------------
  wire rx_push = rx_valid_in && !rx_full;
  wire rx_pop = data_rd && !rx_empty;
  assign rx_ready_out = !rx_full;

  always_ff @(posedge sys_clk_in) begin
    if (rx_push) begin
      rx_mem_q[rx_wp_q] <= rx_data_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      rx_wp_q <= '0;
      rx_rp_q <= '0;
      rx_cnt_q <= '0;
    end else begin
      rx_wp_q <= rx_wp_q + AW'(rx_push);
      rx_rp_q <= rx_rp_q + AW'(rx_pop);
      rx_cnt_q <= rx_cnt_q + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  wire [7:0] cfg_view = {busy_in, master_enable_q, 2'h0, slave_selected_out, pin_sync_q, 1'h1, rx_empty};
  wire [7:0] rx_head = rx_empty ? 8'h00 : rx_mem_q[rx_rp_q];
  wire [7:0] rd_mux = sel_ctrl ? ctrl_q :
                      sel_div ? div_q :
                      sel_data ? rx_head :
                      sel_cfg ? cfg_view : 8'h00;

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      rdata_q <= 8'h00;
    end else if (rd_in) begin
      rdata_q <= rd_mux;
    end
  end

  assign rdata_out = rdata_q;

  // ----------------------------------------------------------------
  // serial clock divider
  // ----------------------------------------------------------------
  wire sck_run = enabled && master_enable_q && busy_in;
  wire sck_wrap = (cnt_q == div_q);

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in || !sck_run) begin
      cnt_q <= 8'h00;
      sck_q <= 1'h0;
      sck_edge_q <= 1'h0;
    end else begin
      cnt_q <= sck_wrap ? 8'h00 : cnt_q + 8'h01;
      sck_q <= sck_q ^ sck_wrap;
      sck_edge_q <= sck_wrap;
    end
  end

  assign serial_clk_out = sck_q;
  assign serial_clk_edge_out = sck_edge_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  // system clocks since the last serial clock toggle
  logic [8:0] hold_q;
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in || !sck_run || sck_wrap) begin
      hold_q <= 9'h001;
    end else begin
      hold_q <= hold_q + 9'h001;
    end
  end

  sequence s_good_load;
    data_wr && tx_buffer_empty && !tx_take;
  endsequence

  sequence s_empty_after;
    !tx_buffer_empty ##1 1'b1;
  endsequence

  sequence s_fault_cond;
    enabled && master_enable_q && sel_mode == `SCS_SEL_INPUT && !pin_sync_q;
  endsequence

  AST_DONE_SET: assert property (enabled && xfer_done_in |=> ctrl_q[`SCS_BIT_DONE])
    else $error("done flag not set after transfer end");
  AST_FLAGS_STICKY: assert property (
      !ctrl_touch |=> (ev_flags & $past(ev_flags)) == $past(ev_flags))
    else $error("event flag cleared without software");
  AST_IRQ_RAISE: assert property (
      enabled && xfer_done_in && irq_enable_in ##1 irq_enable_in |-> irq_out)
    else $error("interrupt missing after done");
  AST_WRITE_COLLISION_FLAG_SET: assert property (data_wr && !tx_buffer_empty |=> ctrl_q[`SCS_BIT_WRITE_COLLISION_FLAG])
    else $error("collision flag not set");
  AST_WRITE_COLLISION_FLAG_DROP: assert property (data_wr && !tx_buffer_empty |=> tx_buf_q == $past(tx_buf_q))
    else $error("colliding write changed transmit buffer");
  AST_MODE_FAULT_FLAG_SET: assert property (s_fault_cond |=> ctrl_q[`SCS_BIT_MODE_FAULT_FLAG])
    else $error("mode fault not flagged");
  AST_OVR_SET: assert property (
      enabled && !master_enable_q && last_bit_in && !rx_empty |=> ctrl_q[`SCS_BIT_OVR])
    else $error("overrun not flagged");
  AST_PIN_3WIRE: assert property (
      sel_mode == `SCS_SEL_3WIRE |-> select_pin_oe_n_out && slave_selected_out)
    else $error("three-wire mode touches select pin");
  AST_PIN_INPUT: assert property (sel_mode == `SCS_SEL_INPUT |-> select_pin_oe_n_out)
    else $error("select pin driven in input mode");
  AST_PIN_DRIVE: assert property (
      sel_mode[1] |-> !select_pin_oe_n_out && select_pin_out == sel_mode[0])
    else $error("select pin output wrong");
  AST_TX_BUFFER_EMPTY_CLEAR: assert property (s_good_load |-> ##1 s_empty_after)
    else $error("buffer empty not cleared on load");
  AST_TX_BUFFER_EMPTY_SET: assert property (tx_take && !data_wr |=> tx_buffer_empty)
    else $error("buffer empty not set on hand-off");
  AST_SCK_HALF: assert property (
      sck_run && $past(sck_run) && sck_q != $past(sck_q)
      |-> $past(hold_q) == {1'b0, $past(div_q)} + 9'h001)
    else $error("serial clock half period wrong");
  AST_SLAVE_NO_SCK: assert property (!master_enable_q |=> !serial_clk_out)
    else $error("serial clock runs in slave mode");
  AST_DATA_READ: assert property (
      data_rd && !rx_empty |=> rdata_out == $past(rx_mem_q[rx_rp_q]))
    else $error("data read wrong");
  AST_DISABLED: assert property (
      !enabled |-> !tx_valid_out ##1 !$rose(ctrl_q[`SCS_BIT_DONE]) || $past(ctrl_touch))
    else $error("disabled port started or finished a transfer");

  // ----------------------------------------------------------------
  // further checks
  // ----------------------------------------------------------------
  sequence s_handoff;
    tx_take && !data_wr;
  endsequence

  sequence s_idle_after;
    !tx_valid_out && tx_buffer_empty;
  endsequence

  AST_TX_HANDOFF: assert property (s_handoff |=> s_idle_after)
    else $error("transmit valid stayed after hand-off");
  AST_TX_HELD: assert property (tx_valid_out && !tx_take && !ctrl_touch |=> tx_valid_out)
    else $error("transmit valid dropped before hand-off");
  AST_TXBUF_HOLD: assert property (!tx_load |=> tx_buf_q == $past(tx_buf_q))
    else $error("transmit buffer changed without a load");
  AST_BMT_HOLD: assert property (!tx_load && !tx_take |=> tx_buffer_empty == $past(tx_buffer_empty))
    else $error("buffer empty bit moved without load or hand-off");
  AST_IRQ_FLAGS: assert property (irq_enable_in && (|ev_flags) |-> irq_out)
    else $error("interrupt missing while a flag is set");
  AST_IRQ_QUIET: assert property (!irq_enable_in || ev_flags == 4'h0 |-> !irq_out)
    else $error("interrupt raised with nothing pending");

  AST_RX_BOUND: assert property (rx_cnt_q <= (AW+1)'(RX_DEPTH))
    else $error("receive buffer count above depth");
  AST_RX_EMPTY_READ: assert property (data_rd && rx_empty |=> rdata_out == 8'h00)
    else $error("empty data read not zero");
  AST_SCK_IDLE: assert property (!sck_run |=> !serial_clk_out && !serial_clk_edge_out)
    else $error("serial clock not idle low");
  AST_SCK_EDGE: assert property (
      serial_clk_edge_out |-> serial_clk_out != $past(serial_clk_out))
    else $error("edge pulse without serial clock change");
  AST_OFF_NO_SCK: assert property (!enabled |=> !serial_clk_out)
    else $error("serial clock runs while port disabled");
  AST_MODE_FAULT_FLAG_MASTER: assert property (
      !master_enable_q && !ctrl_touch |=> !$rose(ctrl_q[`SCS_BIT_MODE_FAULT_FLAG]))
    else $error("mode fault raised in slave mode");
  AST_OVR_SLAVE: assert property (
      master_enable_q && !ctrl_touch |=> !$rose(ctrl_q[`SCS_BIT_OVR]))
    else $error("overrun raised in master mode");
  AST_WRITE_COLLISION_FLAG_CAUSE: assert property (
      !data_wr && !ctrl_touch |=> !$rose(ctrl_q[`SCS_BIT_WRITE_COLLISION_FLAG]))
    else $error("collision flag raised without a data write");

endmodule

`default_nettype wire

// ---- verification/shift_engine_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------
// shift engine stand-in: takes a byte, runs, returns its inverse
// ------------------------------------------------
module shift_engine_model (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic stall_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  input wire logic rx_ready_in,
  output logic tx_ready_out,
  output logic busy_out,
  output logic done_out,
  output logic last_out,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out
);
  logic [5:0] cnt_q;
  logic [7:0] shift_q;

  assign tx_ready_out = !busy_out && !stall_in;

  always_ff @(posedge clk_in) begin
    done_out <= 1'b0;
    last_out <= 1'b0;
    if (!rstn_in) begin
      busy_out <= 1'b0;
      cnt_q <= 6'h00;
      shift_q <= 8'h00;
      rx_valid_out <= 1'b0;
      rx_data_out <= 8'h00;
    end else begin
      // a taken byte no longer shows on the data lines
      if (rx_valid_out && rx_ready_in) begin
        rx_valid_out <= 1'b0;
        rx_data_out <= ~rx_data_out;
      end
      if (tx_valid_in && tx_ready_out) begin
        busy_out <= 1'b1;
        cnt_q <= 6'h28;
        shift_q <= ~tx_data_in;
      end else if (busy_out) begin
        cnt_q <= cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
          last_out <= 1'b1;
          rx_valid_out <= 1'b1;
          rx_data_out <= shift_q;
        end
      end
    end
  end
endmodule

`default_nettype wire

// ---- verification/spi_control_status_clock_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none

module spi_control_status_clock_tb_top;
  import scs_pkg::*;
  logic sys_clk_in, rstn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, bit_wr_in = 1'b0;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out, tx_data_out, rx_data_in;
  logic [2:0] bit_idx_in = 3'h0;
  logic bit_val_in = 1'b0, irq_enable_in = 1'b1, select_pin_in = 1'b1, stall = 1'b0;
  logic irq_out, busy_in, xfer_done_in, last_bit_in, tx_valid_out, tx_ready_in;
  logic rx_valid_in, rx_ready_out, master_enable_out, port_enable_out, slave_selected_out;
  logic serial_clk_out, serial_clk_edge_out, select_pin_out, select_pin_oe_n_out;
  int err_total = 0, cmp_count = 0, n;

  spi_control_status_clock i_dut (.sys_clk_in, .rstn_in, .addr_in, .wdata_in, .wr_in,
    .rd_in, .rdata_out, .bit_wr_in, .bit_idx_in, .bit_val_in, .irq_enable_in, .irq_out,
    .busy_in, .xfer_done_in, .last_bit_in, .tx_data_out, .tx_valid_out, .tx_ready_in,
    .rx_data_in, .rx_valid_in, .rx_ready_out, .master_enable_out, .port_enable_out,
    .slave_selected_out, .serial_clk_out, .serial_clk_edge_out, .select_pin_in,
    .select_pin_out, .select_pin_oe_n_out);

  shift_engine_model i_eng (.clk_in(sys_clk_in), .rstn_in(rstn_in), .stall_in(stall),
    .tx_data_in(tx_data_out), .tx_valid_in(tx_valid_out), .rx_ready_in(rx_ready_out),
    .tx_ready_out(tx_ready_in), .busy_out(busy_in), .done_out(xfer_done_in),
    .last_out(last_bit_in), .rx_data_out(rx_data_in), .rx_valid_out(rx_valid_in));

  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end

  // ------------------------------------------------
  // access and compare tasks
  // ------------------------------------------------
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    @(posedge sys_clk_in);
    chk($sformatf("read %h", a), exp, rdata_out);
  endtask

  task bitw(input logic [2:0] idx, input logic v);
    @(posedge sys_clk_in);
    bit_idx_in <= idx;
    bit_val_in <= v;
    bit_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    bit_wr_in <= 1'b0;
  endtask

  task wait_done;
    int i;
    for (i = 0; i < 100; i++) begin
      @(posedge sys_clk_in);
      #1;
      if (xfer_done_in === 1'b1) break;
    end
    if (i == 100) begin
      err_total++;
      end_of_test;
    end
    @(posedge sys_clk_in);
  endtask

  task end_of_test;
    $display("mismatches %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    rd(8'hf8, 8'h06);
    chk("oe_n", 8'h01, {7'h00, select_pin_oe_n_out});
    rd(8'h55, 8'h00);
    wr(8'ha2, 8'h03);
    rd(8'ha2, 8'h03);
    wr(8'ha3, 8'h11);
    rd(8'hf8, 8'h04);
    chk("tx_valid", 8'h00, {7'h00, tx_valid_out});
    wr(8'hf8, 8'h05);
    wait_done;
    rd(8'hf8, 8'h87);
    chk("port_en", 8'h01, {7'h00, port_enable_out});
    chk("irq", 8'h01, {7'h00, irq_out});
    rd(8'ha3, 8'hee);
    repeat (20) @(posedge sys_clk_in);
    rd(8'hf8, 8'h87);
    irq_enable_in <= 1'b0;
    @(posedge sys_clk_in);
    chk("irq off", 8'h00, {7'h00, irq_out});
    irq_enable_in <= 1'b1;
    bitw(3'h7, 1'b0);
    rd(8'hf8, 8'h07);
    stall <= 1'b1;
    wr(8'ha3, 8'h22);
    wr(8'ha3, 8'h33);
    rd(8'hf8, 8'h45);
    chk("tx_data", 8'h22, tx_data_out);
    stall <= 1'b0;
    wait_done;
    wr(8'ha3, 8'h44);
    wait_done;
    rd(8'hf8, 8'hd7);
    wr(8'hf8, 8'h07);
    rd(8'hf8, 8'h07);
    rd(8'ha3, 8'hdd);
    rd(8'ha3, 8'hbb);
    wr(8'ha3, 8'h55);
    n = 0;
    repeat (30) begin
      @(posedge sys_clk_in);
      #1;
      if (serial_clk_edge_out !== 1'b0) n++;
    end
    chk("slave sck", 8'h00, n[7:0]);
    wait_done;
    wr(8'ha1, 8'h40);
    rd(8'ha1, 8'h46);
    chk("master_enable", 8'h01, {7'h00, master_enable_out});
    wr(8'ha3, 8'h66);
    n = 0;
    while (serial_clk_edge_out !== 1'b1 && n < 200) begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end
    if (n == 200) err_total++;
    chk("sck level", 8'h01, {7'h00, serial_clk_out});
    n = 0;
    do begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end while (serial_clk_edge_out !== 1'b1 && n < 200);
    chk("sck half", 8'h04, n[7:0]);
    wait_done;
    wr(8'hf8, 8'h07);
    select_pin_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    rd(8'hf8, 8'h27);
    for (int m = 0; m < 4; m++) begin
      wr(8'hf8, {4'h0, m[1:0], 2'h3});
      @(posedge sys_clk_in);
      #1;
      chk("oe_n", {7'h00, ~m[1]}, {7'h00, select_pin_oe_n_out});
      if (m[1]) chk("pin", {7'h00, m[0]}, {7'h00, select_pin_out});
      if (m == 0) chk("sel", 8'h01, {7'h00, slave_selected_out});
    end
    end_of_test;
  end
endmodule

`default_nettype wire
